// ===== src/dp_pkg.sv
// Constants and types for the programmable logic datapath.
// Assumes an APB master on the same clock as the datapath.
package dp_pkg;
	localparam int W = 8;
	localparam int NINSN = 8;
	localparam logic [7:0] OFF_A0 = 8'h00;
	localparam logic [7:0] OFF_A1 = 8'h04;
	localparam logic [7:0] OFF_D0 = 8'h08;
	localparam logic [7:0] OFF_D1 = 8'h0C;
	localparam logic [7:0] OFF_F0 = 8'h10;
	localparam logic [7:0] OFF_F1 = 8'h14;
	localparam logic [7:0] OFF_FSTAT = 8'h18;
	localparam logic [7:0] OFF_CTRL = 8'h1C;
	localparam logic [7:0] OFF_STAT = 8'h20;
	localparam logic [7:0] OFF_STCFG = 8'h24;
	localparam logic [7:0] OFF_STSEL = 8'h28;
	localparam logic [7:0] OFF_CMASK = 8'h2C;
	localparam logic [7:0] OFF_ORMASK = 8'h30;
	localparam logic [7:0] OFF_DPCFG = 8'h34;
	localparam logic [7:0] OFF_OUTSEL = 8'h38;
	localparam logic [7:0] OFF_INSN = 8'h40;
	// Datapath configuration fields
	localparam int CFG_MSB = 0;
	localparam int CFG_CMP0 = 3;
	localparam int CFG_CMP1 = 5;
	localparam int CFG_DIR = 7;
	localparam int CFG_TMUX = 9;
	localparam int CFG_CHAIN = 10;
	localparam logic [31:0] DPCFG_RST = 32'h0000_0007;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// Routing input positions
	localparam int RI_SIN = 3;
	localparam int RI_STB0 = 4;
	// Condition vector positions
	localparam int C_EQ0 = 0;
	localparam int C_LT0 = 1;
	localparam int C_EQ1 = 2;
	localparam int C_LT1 = 3;
	localparam int C_ZERO = 4;
	localparam int C_ONES = 5;
	localparam int C_OV = 6;
	localparam int C_CO = 7;
	localparam int C_SO = 8;
	localparam int C_FST = 9;
	typedef enum logic [2:0] {OP_PASS, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_XOR, OP_AND,
		OP_OR} alu_op_e;
	typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} shift_e;
	typedef struct packed {
		logic wr_a1;
		logic wr_a0;
		logic [1:0] srcb;
		logic srca;
		logic crc;
		logic chain_in;
		logic mask_en;
		shift_e shift;
		alu_op_e op;
	} insn_s;
	typedef struct packed {
		logic carry;
		logic shift;
		logic eq;
		logic lt;
	} chain_s;
endpackage : dp_pkg

// ===== src/logic_datapath.sv
// One 8-bit datapath of a universal_logic_block with its control and status pair.
// Assumes routing inputs and chain inputs come from logic on pclk.
// Operation
// - Shift left, right, nibble swap, OR mask chosen apart from ALU op.
// - Two comparators, each masking its operands first.
// - Comparator operands chosen from accumulators and data registers.
// - Zero, all-ones and overflow conditions generated too.
// - Selected conditions drive the routing outputs.
// - Comparator 0 chains to neighbours for wider compares; comparator 1 does not.
// - Programmable MSB for arithmetic and shifts; masking sets width.
// - One CRC or pseudo_random_sequence step per clock, programmable.
// - Wider CRC needs outside logic or chained neighbours.
// - Two four-byte FIFOs, direction set per FIFO.
// - Input: bus writes, datapath reads; output: reverse.
// - FIFO status selectable as datapath outputs.
// - Carry, shift and conditions pass to and from neighbours.
// - Time multiplexing shares ALU between two sets; carry registered.
// - Six routing inputs and six routing outputs.
// - Each routing output carries a condition or serial output.
// - Bus-written control bits drive routing signals.
// - Status register is read-only, taken from internal signals.
// - Each status bit has its own routing choice; control bits drive ctl_out directly.
// - Sticky status bits hold events until a read clears them.
//
// Design decisions made here: the address map and the APB slave port.
module logic_datapath import dp_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] route_in,
	output logic [5:0] route_out,
	output logic [7:0] ctl_out,
	input wire chain_s chain_in,
	output chain_s chain_out
);
	logic [W-1:0] a0, a1, d0, d1, ctrl, stcfg, ormask, hold;
	logic [15:0] cmask;
	logic [31:0] dpcfg, stsel, outsel;
	logic [12:0] insn_mem [NINSN];
	logic [15:0] cset0, cset1;
	logic carry_q, shift_q, phase;

	// Bus decode
	wire setup_rd = psel & ~penable & ~pwrite;
	wire acc = psel & penable;
	wire bus_wr = acc & pwrite;
	wire bus_rd = acc & ~pwrite;
	wire in_insn = paddr[7:5] == OFF_INSN[7:5] && paddr[1:0] == 2'b00;
	wire [2:0] insn_idx = paddr[4:2];
	wire hit = in_insn || (paddr[1:0] == 2'b00 && paddr <= OFF_OUTSEL);
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;

	// Configuration
	wire [2:0] msb = dpcfg[CFG_MSB+:3];
	wire tmux = dpcfg[CFG_TMUX];
	wire chain_en = dpcfg[CFG_CHAIN];
	wire [W-1:0] wmask = 8'hFF >> (3'd7 - msb);
	wire insn_s insn = insn_s'(insn_mem[route_in[2:0]]);
	wire set = tmux & phase;

	// Operand selection
	wire [W-1:0] opa = (tmux ? set : insn.srca) ? a1 : a0;
	wire [W-1:0] opb_sel = insn.srcb == 2'd0 ? d0 : insn.srcb == 2'd1 ? d1 :
		insn.srcb == 2'd2 ? a0 : a1;
	wire [W-1:0] opb = tmux ? (set ? d1 : d0) : opb_sel;
	wire [W-1:0] am = opa & wmask;
	wire [W-1:0] bm = opb & wmask;
	// Second half of a 16-bit step takes the stored carry and shift
	wire cin = set ? carry_q : (insn.chain_in & chain_in.carry);
	wire sin = set ? shift_q : (insn.chain_in ? chain_in.shift : route_in[RI_SIN]);

	function automatic logic [8:0] alu_f(alu_op_e op, logic [W-1:0] a, logic [W-1:0] b,
		logic c);
		unique case (op)
			OP_PASS: alu_f = {1'b0, a};
			OP_INC: alu_f = {1'b0, a} + 9'h001;
			OP_DEC: alu_f = {1'b0, a} - 9'h001;
			OP_ADD: alu_f = {1'b0, a} + {1'b0, b} + {8'h00, c};
			OP_SUB: alu_f = {1'b0, a} - {1'b0, b} - {8'h00, c};
			OP_XOR: alu_f = {1'b0, a ^ b};
			OP_AND: alu_f = {1'b0, a & b};
			OP_OR: alu_f = {1'b0, a | b};
		endcase
	endfunction : alu_f

	// ALU with variable MSB
	wire [8:0] sum = alu_f(insn.op, am, bm, cin);
	wire [3:0] msb1 = {1'b0, msb} + 4'd1;
	wire cout = sum[msb1];
	wire [W-1:0] res = sum[7:0] & wmask;
	wire bsign = insn.op == OP_SUB ? ~bm[msb] : bm[msb];
	wire is_arith = insn.op == OP_ADD || insn.op == OP_SUB;
	wire ov = is_arith && am[msb] == bsign && res[msb] != am[msb];

	// Shifter, independent of the ALU op
	wire [W-1:0] shl = ((res << 1) | {7'h00, sin}) & wmask;
	wire [W-1:0] shr = (res >> 1) | ({7'h00, sin} << msb);
	wire [W-1:0] swp = {res[3:0], res[7:4]};
	wire [W-1:0] shv = insn.shift == SH_LEFT ? shl : insn.shift == SH_RIGHT ? shr :
		insn.shift == SH_SWAP ? swp : res;
	wire sh_out = insn.shift == SH_LEFT ? res[msb] : res[0];

	// CRC / pseudo_random_sequence step; polynomial is operand B
	wire fb = am[msb] ^ sin;
	wire [W-1:0] crcv = ((am << 1) & wmask) ^ (fb ? bm : 8'h00);
	wire [W-1:0] dp_pre = insn.crc ? crcv : shv;
	wire [W-1:0] dp_res = insn.mask_en ? (dp_pre | ormask) & wmask : dp_pre;
	wire so = insn.crc ? fb : sh_out;

	// Comparators with masks and chaining
	function automatic logic [15:0] pair_f(logic [1:0] s, logic [W-1:0] x0, x1, y0, y1);
		unique case (s)
			2'd0: pair_f = {x0, y0};
			2'd1: pair_f = {x1, y1};
			2'd2: pair_f = {x0, x1};
			2'd3: pair_f = {x0, y1};
		endcase
	endfunction : pair_f
	wire [15:0] p0 = pair_f(dpcfg[CFG_CMP0+:2], a0, a1, d0, d1);
	wire [15:0] p1 = pair_f(dpcfg[CFG_CMP1+:2], a0, a1, d0, d1);
	wire [W-1:0] m0x = p0[15:8] & cmask[7:0];
	wire [W-1:0] m0y = p0[7:0] & cmask[7:0];
	wire [W-1:0] m1x = p1[15:8] & cmask[15:8];
	wire [W-1:0] m1y = p1[7:0] & cmask[15:8];
	wire ceq0 = m0x == m0y && (!chain_en || chain_in.eq);
	wire clt0 = m0x < m0y || (m0x == m0y && chain_en && chain_in.lt);
	wire ceq1 = m1x == m1y;
	wire clt1 = m1x < m1y;
	assign chain_out = '{carry: cout, shift: so, eq: ceq0, lt: clt0};

	// FIFOs, one per data register
	logic [1:0] fempty, ffull, fpush, fpop;
	logic [W-1:0] fhead [2];
	logic [2:0] fcnt [2];
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_fifo
			logic [W-1:0] mem [4];
			logic [1:0] wp, rp;
			wire dir_out = dpcfg[CFG_DIR+gi];
			wire [7:0] foff = gi ? OFF_F1 : OFF_F0;
			wire stb = route_in[RI_STB0+gi];
			wire bus_here = paddr == foff;
			// Output mode: datapath fills, bus drains; input mode reversed
			wire push_try = dir_out ? stb : bus_wr & bus_here;
			wire pop_try = dir_out ? bus_rd & bus_here : stb;
			wire [W-1:0] pdata = dir_out ? (gi ? a1 : a0) : pwdata[7:0];
			assign fempty[gi] = fcnt[gi] == 3'd0;
			assign ffull[gi] = fcnt[gi] == 3'd4;
			assign fpush[gi] = push_try & ~ffull[gi];
			assign fpop[gi] = pop_try & ~fempty[gi];
			assign fhead[gi] = mem[rp];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wp <= 2'd0;
					rp <= 2'd0;
					fcnt[gi] <= 3'd0;
				end else begin
					wp <= wp + {1'b0, fpush[gi]};
					rp <= rp + {1'b0, fpop[gi]};
					fcnt[gi] <= fcnt[gi] + {2'b00, fpush[gi]} - {2'b00, fpop[gi]};
				end
			end
			always_ff @(posedge pclk) begin
				if (fpush[gi]) begin
					mem[wp] <= pdata;
				end
			end
		end
	endgenerate

	// Condition vector and its two registered sets
	wire [15:0] cond = {1'b0, a1 == 8'h00, a0 == 8'h00, ffull[1], fempty[1], ffull[0], fempty[0],
		so, cout, ov, dp_res == wmask, dp_res == 8'h00, clt1, ceq1, clt0, ceq0};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cset0 <= 16'h0000;
			cset1 <= 16'h0000;
		end else if (set) begin
			cset1 <= cond;
		end else begin
			cset0 <= cond;
		end
	end
	wire [31:0] csrc = {cset1, cset0};

	// Routing outputs: five select bits each
	logic [5:0] next_route;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_rout
			assign next_route[gi] = csrc[outsel[gi*5+:5]];
		end
	endgenerate

	// Status: per-bit source select, optional sticky capture
	logic [W-1:0] st_src;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_stat
			assign st_src[gi] = cset0[stsel[gi*4+:4]];
		end
	endgenerate
	wire rd_stat = bus_rd && paddr == OFF_STAT;
	// Set wins over the read clear so no event slips through
	wire [W-1:0] next_hold = (hold & ~{8{rd_stat}}) | (st_src & stcfg);
	wire [W-1:0] stat_val = (stcfg & (hold | st_src)) | (~stcfg & st_src);

	// Read mux, captured in the setup phase
	wire [31:0] rd_reg = paddr == OFF_A0 ? {24'h0, a0} : paddr == OFF_A1 ? {24'h0, a1} :
		paddr == OFF_D0 ? {24'h0, d0} : paddr == OFF_D1 ? {24'h0, d1} :
		paddr == OFF_F0 ? {24'h0, fempty[0] ? 8'h00 : fhead[0]} :
		paddr == OFF_F1 ? {24'h0, fempty[1] ? 8'h00 : fhead[1]} :
		paddr == OFF_FSTAT ? {28'h0, ffull[1], fempty[1], ffull[0], fempty[0]} :
		paddr == OFF_CTRL ? {24'h0, ctrl} : paddr == OFF_STAT ? {24'h0, stat_val} :
		paddr == OFF_STCFG ? {24'h0, stcfg} : paddr == OFF_STSEL ? stsel :
		paddr == OFF_CMASK ? {16'h0, cmask} : paddr == OFF_ORMASK ? {24'h0, ormask} :
		paddr == OFF_DPCFG ? dpcfg : paddr == OFF_OUTSEL ? outsel : 32'h0;
	wire [31:0] rd_val = in_insn ? {19'h0, insn_mem[insn_idx]} : hit ? rd_reg : 32'h0;
	assign ctl_out = ctrl;

	// Datapath register writes; bus write takes precedence
	wire wa0 = tmux ? ~phase : insn.wr_a0;
	wire wa1 = tmux ? phase : insn.wr_a1;
	wire [W-1:0] next_a0 = bus_wr && paddr == OFF_A0 ? pwdata[7:0] : wa0 ? dp_res : a0;
	wire [W-1:0] next_a1 = bus_wr && paddr == OFF_A1 ? pwdata[7:0] : wa1 ? dp_res : a1;
	wire [W-1:0] next_d0 = bus_wr && paddr == OFF_D0 ? pwdata[7:0] : fpop[0] &&
		!dpcfg[CFG_DIR] ? fhead[0] : d0;
	wire [W-1:0] next_d1 = bus_wr && paddr == OFF_D1 ? pwdata[7:0] : fpop[1] &&
		!dpcfg[CFG_DIR+1] ? fhead[1] : d1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{a0, a1, d0, d1} <= 32'h0;
			{carry_q, shift_q, phase} <= 3'b000;
			{hold, route_out} <= 14'h0;
			prdata <= REG_RST;
		end else begin
			{a0, a1, d0, d1} <= {next_a0, next_a1, next_d0, next_d1};
			{carry_q, shift_q} <= {cout, so};
			phase <= tmux & ~phase;
			hold <= next_hold;
			route_out <= next_route;
			if (setup_rd) begin
				prdata <= rd_val;
			end
		end
	end

	// Configuration registers
	wire wr_cfg = bus_wr && !in_insn;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ctrl, stcfg, ormask} <= 24'h0;
			{stsel, outsel, cmask} <= 80'h0;
			dpcfg <= DPCFG_RST;
		end else if (wr_cfg) begin
			if (paddr == OFF_CTRL) ctrl <= pwdata[7:0];
			if (paddr == OFF_STCFG) stcfg <= pwdata[7:0];
			if (paddr == OFF_ORMASK) ormask <= pwdata[7:0];
			if (paddr == OFF_STSEL) stsel <= pwdata;
			if (paddr == OFF_OUTSEL) outsel <= pwdata;
			if (paddr == OFF_CMASK) cmask <= pwdata[15:0];
			if (paddr == OFF_DPCFG) dpcfg <= pwdata;
		end
	end

	// Instruction store is read-only to the datapath
	generate
		for (gi = 0; gi < NINSN; gi++) begin : g_insn
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					insn_mem[gi] <= 13'h0000;
				end else if (bus_wr && in_insn && insn_idx == gi) begin
					insn_mem[gi] <= pwdata[12:0];
				end
			end
		end
	endgenerate

	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_stat_read;
		setup_rd && paddr == OFF_STAT ##1 acc;
	endsequence
	a_sticky_clear: assert property (s_stat_read ##0 (st_src & stcfg) == 8'h00 |=>
		(hold & stcfg) == 8'h00) else $error("sticky status not cleared by read");
	a_sticky_keep: assert property ((st_src[0] & stcfg[0]) |=> hold[0] [*1] ##0
		stat_val[0]) else $error("sticky event lost");
	a_fifo_full_hold: assert property (ffull[0] && !fpop[0] |=> fcnt[0] == 3'd4)
		else $error("full fifo changed on write");
	a_fifo_empty_hold: assert property (fempty[1] && !fpush[1] |=> fcnt[1] == 3'd0)
		else $error("empty fifo changed on read");
	a_ctl_drive: assert property (bus_wr && paddr == OFF_CTRL |=> ctl_out == $past(pwdata[7:0]))
		else $error("control bits not driven");
	a_tmux_alternate: assert property (tmux ##1 tmux |-> phase != $past(phase))
		else $error("time multiplex phase stuck");
	a_chain_cmp: assert property (chain_en && !chain_in.eq |-> !chain_out.eq ##1 !cset0[C_EQ0]
		|| set || $past(set)) else $error("chained compare ignored");
	a_msb_width: assert property (!bus_wr && wa0 |=> (a0 & ~$past(wmask)) == 8'h00)
		else $error("result exceeds programmed msb");
	a_route_sel: assert property (##1 route_out[0] == $past(csrc[outsel[4:0]]))
		else $error("routing output mismatch");
endmodule : logic_datapath

// ===== test/routing_model.sv
// Routing matrix model: drives operation select, serial in and FIFO strobes.
// Assumes the datapath samples route_in on rising pclk.
module routing_model import dp_pkg::*; (
	input wire logic pclk,
	output logic [5:0] route_in,
	output chain_s chain_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		route_in = 6'h00;
		chain_in = '0;
	end
	// Select held one cycle only, so exactly one step executes
	task automatic pulse(input logic [5:0] v);
		@(posedge pclk);
		route_in <= v;
		@(posedge pclk);
		route_in <= 6'h00;
	endtask : pulse
	// Neighbour carry, shift and compare flags, changed just after an edge
	task automatic set_chain(input chain_s c);
		@(posedge pclk);
		chain_in <= c;
	endtask : set_chain
	// Select held for n edges, for time-multiplexed pairs of steps
	task automatic hold_sel(input logic [5:0] v, input int n);
		@(posedge pclk);
		route_in <= v;
		repeat (n) @(posedge pclk);
		route_in <= 6'h00;
	endtask : hold_sel
endmodule : routing_model

// ===== test/tb_top.sv
// Self-checking bench for the logic datapath over APB.
// Assumes zero-wait APB slave and routing_model as far side.
module tb_top import dp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, ctl_out;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] route_in, route_out;
	chain_s chain_in, chain_out;
	int errors, compares;
	logic_datapath u_logic_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .route_in(route_in),
		.route_out(route_out), .ctl_out(ctl_out), .chain_in(chain_in),
		.chain_out(chain_out));
	routing_model u_routing_model (.pclk(pclk), .route_in(route_in), .chain_in(chain_in));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic t_reset;
		apb(1'b0, OFF_DPCFG, 32'h0);
		chk(rd, DPCFG_RST);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, REG_RST);
		apb(1'b0, OFF_FSTAT, 32'h0);
		chk(rd, 32'h0000_0005);
		chk({24'h0, ctl_out}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs;
		apb(1'b1, OFF_CTRL, 32'h0000_00A5);
		@(negedge pclk);
		chk({24'h0, ctl_out}, 32'h0000_00A5);
		apb(1'b1, OFF_FSTAT, 32'h0);
		apb(1'b0, OFF_FSTAT, 32'h0);
		chk(rd, 32'h0000_0005);
		apb(1'b0, 8'h3C, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test registers done");
	endtask : t_regs
	task automatic t_alu;
		apb(1'b1, OFF_INSN + 8'h04, 32'h0000_0803);
		apb(1'b1, OFF_INSN + 8'h08, 32'h0000_0818);
		apb(1'b1, OFF_INSN + 8'h0C, 32'h0000_0820);
		apb(1'b1, OFF_INSN + 8'h10, 32'h0000_0808);
		apb(1'b1, OFF_A0, 32'h0000_00FE);
		apb(1'b1, OFF_D0, 32'h0000_0005);
		u_routing_model.pulse(6'h01);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_0003);
		u_routing_model.pulse(6'h02);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_0030);
		apb(1'b1, OFF_ORMASK, 32'h0000_000F);
		u_routing_model.pulse(6'h03);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_003F);
		// Narrow width: shift must drop bits above position 3
		apb(1'b1, OFF_DPCFG, 32'h0000_0003);
		u_routing_model.pulse(6'h04);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_000E);
		apb(1'b1, OFF_DPCFG, DPCFG_RST);
		$display("test alu done");
	endtask : t_alu
	task automatic t_fifo;
		for (int i = 0; i < 4; i++) apb(1'b1, OFF_F0, 32'h10 + i);
		apb(1'b0, OFF_FSTAT, 32'h0);
		chk(rd, 32'h0000_0006);
		apb(1'b1, OFF_F0, 32'h0000_00EE);
		for (int i = 0; i < 4; i++) begin
			u_routing_model.pulse(6'h10);
			apb(1'b0, OFF_D0, 32'h0);
			chk(rd, 32'h10 + i);
		end
		apb(1'b0, OFF_FSTAT, 32'h0);
		chk(rd, 32'h0000_0005);
		u_routing_model.pulse(6'h10);
		apb(1'b0, OFF_D0, 32'h0);
		chk(rd, 32'h0000_0013);
		apb(1'b1, OFF_DPCFG, 32'h0000_0107);
		apb(1'b1, OFF_A1, 32'h0000_005A);
		u_routing_model.pulse(6'h20);
		apb(1'b0, OFF_F1, 32'h0);
		chk(rd, 32'h0000_005A);
		apb(1'b0, OFF_F1, 32'h0);
		chk(rd, 32'h0);
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_chain;
		apb(1'b1, OFF_DPCFG, 32'h0000_0407);
		apb(1'b1, OFF_OUTSEL, 32'h0000_0020);
		u_routing_model.set_chain(chain_s'(4'h1));
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk({30'h0, route_out[1:0]}, 32'h0000_0002);
		u_routing_model.set_chain(chain_s'(4'h2));
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk({30'h0, route_out[1:0]}, 32'h0000_0001);
		apb(1'b1, OFF_STCFG, 32'h0000_0001);
		u_routing_model.set_chain(chain_s'(4'h0));
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk({30'h0, route_out[1:0]}, 32'h0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OFF_INSN + 8'h14, 32'h0000_0843);
		apb(1'b1, OFF_A0, 32'h0000_0001);
		apb(1'b1, OFF_D0, 32'h0000_0002);
		u_routing_model.set_chain(chain_s'(4'hC));
		u_routing_model.pulse(6'h05);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_0004);
		u_routing_model.pulse(6'h0C);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_0009);
		u_routing_model.set_chain(chain_s'(4'h0));
		apb(1'b1, OFF_STCFG, 32'h0);
		apb(1'b1, OFF_OUTSEL, 32'h0);
		apb(1'b1, OFF_DPCFG, DPCFG_RST);
		$display("test chain done");
	endtask : t_chain
	task automatic t_tmux;
		apb(1'b1, OFF_A0, 32'h0000_00FF);
		apb(1'b1, OFF_A1, 32'h0);
		apb(1'b1, OFF_D0, 32'h0000_0001);
		apb(1'b1, OFF_D1, 32'h0);
		apb(1'b1, OFF_DPCFG, 32'h0000_0207);
		// Four steps cover both phase orders; low carry must reach A1
		u_routing_model.hold_sel(6'h01, 4);
		apb(1'b1, OFF_DPCFG, DPCFG_RST);
		apb(1'b0, OFF_A0, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, OFF_A1, 32'h0);
		chk(rd, 32'h0000_0001);
		$display("test time multiplex done");
	endtask : t_tmux
	task automatic wrap_up;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		errors = 0;
		compares = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_alu();
		t_fifo();
		t_chain();
		t_tmux();
		wrap_up();
	end
	// Whole run needs a few hundred cycles; this is far beyond it
	initial begin
		#100us;
		errors++;
		wrap_up();
	end
endmodule : tb_top
